// ==== rtl/port_phy_tune_defs.svh ====
// register offsets, field positions, reset values and codes of the port tuning bank
// Function
// - squelch code 000 is the 100 mV trip point and codes 001 to 101 lower it in 12.5 mV steps.
// - squelch code 110 raises the trip point by 25 mV and code 111 raises it by 12.5 mV.
// - drive code 000 is nominal current, 001 is 5 percent less and 010 is 10 percent more.
// - drive code 011 is 5 percent more, 100 is 20 percent more and 101 is 15 percent more.
// - drive code 110 is 30 percent more and 111 is 25 percent more.
// - port 1 link status at 0x65c0 shows state in bits 7:4, sub-state in 2:0, bit 3 reserved.
// - port 2 link status sits at 0x69c0 with the same read-only layout as port 1.
// - port 1 squelch register sits at 0x64cc, bits 7:3 read-only reserved, bits 2:0 writable.
// - port 2 drive register sits at 0x68ca with read-write bits 7:3, squelch register at 0x68cc.
// - port 3 drive register sits at 0x6cca and squelch register at 0x6ccc, same layouts.
// - link state codes 00h to 0bh are U0, U1, U2, U3, disabled, rx detect, inactive,
//   polling, recovery, hot reset, compliance and loopback.
`ifndef PORT_PHY_TUNE_DEFS_SVH
`define PORT_PHY_TUNE_DEFS_SVH

// register offsets
`define P1_DRIVE_OFS    16'h64ca
`define P1_SQUELCH_OFS  16'h64cc
`define P1_STATUS_OFS   16'h65c0
`define P2_DRIVE_OFS    16'h68ca
`define P2_SQUELCH_OFS  16'h68cc
`define P2_STATUS_OFS   16'h69c0
`define P3_DRIVE_OFS    16'h6cca
`define P3_SQUELCH_OFS  16'h6ccc
`define P3_STATUS_OFS   16'h6dc0

// field positions
`define TUNE_FIELD_MSB  2
`define STATE_FIELD_MSB 7
`define STATE_FIELD_LSB 4
`define SUB_FIELD_MSB   2

// reset values
`define DRIVE_RESET     8'h00
`define SQUELCH_RESET   3'h0
`define READ_IDLE       8'h00

// squelch trip points in tenths of a millivolt
`define TRIP_NOMINAL    11'h3e8
`define TRIP_STEP       11'h07d

// highest defined link state code
`define LINK_CODE_MAX   4'hb

`endif

// ==== rtl/port_phy_tune_pkg.sv ====
// types shared by the port tuning and link status bank
package port_phy_tune_pkg;

  // link state codes as reported by the link state machine
  typedef enum logic [3:0] {
    LINK_U0          = 4'h0,
    LINK_U1          = 4'h1,
    LINK_U2          = 4'h2,
    LINK_U3          = 4'h3,
    LINK_DISABLED    = 4'h4,
    LINK_RX_DETECT   = 4'h5,
    LINK_INACTIVE    = 4'h6,
    LINK_POLLING     = 4'h7,
    LINK_RECOVERY    = 4'h8,
    LINK_HOT_RESET   = 4'h9,
    LINK_COMPLIANCE  = 4'ha,
    LINK_LOOPBACK    = 4'hb,
    LINK_UNDEFINED   = 4'hf
  } link_state_t;

  // kind of register an address hits
  typedef enum logic [1:0] {
    HIT_NONE    = 2'h0,
    HIT_DRIVE   = 2'h1,
    HIT_SQUELCH = 2'h3,
    HIT_STATUS  = 2'h2
  } reg_hit_t;

  // signed drive current change in percent
  typedef logic signed [5:0] drive_pct_t;

  // squelch trip point in tenths of a millivolt
  typedef logic [10:0] trip_t;

endpackage

// ==== rtl/port_phy_tune_link_status_regs.sv ====
// per-port drive, squelch and link status registers for downstream ports 1 to 3
//
// Decided for this implementation: the plain strobed port.
`include "port_phy_tune_defs.svh"

module port_phy_tune_link_status_regs (
  input  wire logic                           core_clk,
  input  wire logic                           rst,
  // register port
  input  wire logic [15:0]                    regAddr,
  input  wire logic [7:0]                     regWrData,
  input  wire logic                           regWrite,
  input  wire logic                           regRead,
  output logic [7:0]                          regRdData,
  // live link state machine outputs
  input  wire logic [3:0]                     p1LinkState,
  input  wire logic [2:0]                     p1LinkSubState,
  input  wire logic [3:0]                     p2LinkState,
  input  wire logic [2:0]                     p2LinkSubState,
  input  wire logic [3:0]                     p3LinkState,
  input  wire logic [2:0]                     p3LinkSubState,
  // raw tuning codes to the analog front end
  output logic [2:0]                          p1DriveAdjust,
  output logic [2:0]                          p2DriveAdjust,
  output logic [2:0]                          p3DriveAdjust,
  output logic [2:0]                          p1SquelchAdjust,
  output logic [2:0]                          p2SquelchAdjust,
  output logic [2:0]                          p3SquelchAdjust,
  // decoded tuning values
  output port_phy_tune_pkg::drive_pct_t       p1DrivePercent,
  output port_phy_tune_pkg::drive_pct_t       p2DrivePercent,
  output port_phy_tune_pkg::drive_pct_t       p3DrivePercent,
  output port_phy_tune_pkg::trip_t            p1SquelchTrip,
  output port_phy_tune_pkg::trip_t            p2SquelchTrip,
  output port_phy_tune_pkg::trip_t            p3SquelchTrip,
  // decoded link states
  output port_phy_tune_pkg::link_state_t      p1LinkName,
  output port_phy_tune_pkg::link_state_t      p2LinkName,
  output port_phy_tune_pkg::link_state_t      p3LinkName,
  output logic                                p1LinkCodeValid,
  output logic                                p2LinkCodeValid,
  output logic                                p3LinkCodeValid
);

  // register storage, indexed by port number
  logic [7:0]                       driveReg       [1:3];
  logic [2:0]                       squelchReg     [1:3];
  logic [3:0]                       linkCode       [1:3];
  logic [2:0]                       linkSub        [1:3];
  port_phy_tune_pkg::drive_pct_t    drivePct       [1:3];
  port_phy_tune_pkg::trip_t         tripPoint      [1:3];
  port_phy_tune_pkg::link_state_t   linkName       [1:3];
  logic [3:1]                       linkValid;
  logic [7:0]                       next_regRdData;

  // offset of the drive register of a port
  function automatic logic [15:0] driveOfs(input int port);
    case (port)
      1:       driveOfs = `P1_DRIVE_OFS;
      2:       driveOfs = `P2_DRIVE_OFS;
      3:       driveOfs = `P3_DRIVE_OFS;
      default: driveOfs = 16'h0000;
    endcase
  endfunction

  // offset of the squelch register of a port
  function automatic logic [15:0] squelchOfs(input int port);
    case (port)
      1:       squelchOfs = `P1_SQUELCH_OFS;
      2:       squelchOfs = `P2_SQUELCH_OFS;
      3:       squelchOfs = `P3_SQUELCH_OFS;
      default: squelchOfs = 16'h0000;
    endcase
  endfunction

  // offset of the link status register of a port
  function automatic logic [15:0] statusOfs(input int port);
    case (port)
      1:       statusOfs = `P1_STATUS_OFS;
      2:       statusOfs = `P2_STATUS_OFS;
      3:       statusOfs = `P3_STATUS_OFS;
      default: statusOfs = 16'h0000;
    endcase
  endfunction

  // which register of a port an address selects
  function automatic port_phy_tune_pkg::reg_hit_t hitOf(input logic [15:0] addr,
                                                        input int          port);
    if (addr == driveOfs(port)) begin
      hitOf = port_phy_tune_pkg::HIT_DRIVE;
    end else if (addr == squelchOfs(port)) begin
      hitOf = port_phy_tune_pkg::HIT_SQUELCH;
    end else if (addr == statusOfs(port)) begin
      hitOf = port_phy_tune_pkg::HIT_STATUS;
    end else begin
      hitOf = port_phy_tune_pkg::HIT_NONE;
    end
  endfunction

  // drive code to percent change of output current
  function automatic port_phy_tune_pkg::drive_pct_t drivePctOf(input logic [2:0] code);
    unique case (code)
      3'h0: drivePctOf = 6'sd0;
      3'h1: drivePctOf = -6'sd5;
      3'h2: drivePctOf = 6'sd10;
      3'h3: drivePctOf = 6'sd5;
      3'h4: drivePctOf = 6'sd20;
      3'h5: drivePctOf = 6'sd15;
      3'h6: drivePctOf = 6'sd30;
      3'h7: drivePctOf = 6'sd25;
    endcase
  endfunction

  // squelch code to trip point in tenths of a millivolt
  function automatic port_phy_tune_pkg::trip_t tripOf(input logic [2:0] code);
    unique case (code)
      3'h6:    tripOf = 11'(`TRIP_NOMINAL + 2 * `TRIP_STEP);
      3'h7:    tripOf = 11'(`TRIP_NOMINAL + `TRIP_STEP);
      default: tripOf = 11'(`TRIP_NOMINAL - code * `TRIP_STEP);
    endcase
  endfunction

  // link code to named state, unknown codes flagged
  function automatic port_phy_tune_pkg::link_state_t linkNameOf(input logic [3:0] code);
    if (code <= `LINK_CODE_MAX) begin
      linkNameOf = port_phy_tune_pkg::link_state_t'(code);
    end else begin
      linkNameOf = port_phy_tune_pkg::LINK_UNDEFINED;
    end
  endfunction

  // gather the live link inputs per port
  assign linkCode[1] = p1LinkState;
  assign linkCode[2] = p2LinkState;
  assign linkCode[3] = p3LinkState;
  assign linkSub[1]  = p1LinkSubState;
  assign linkSub[2]  = p2LinkSubState;
  assign linkSub[3]  = p3LinkSubState;

  // drive registers, all eight bits writable
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int p = 1; p <= 3; p++) begin
        driveReg[p] <= `DRIVE_RESET;
      end
    end else if (regWrite) begin
      for (int p = 1; p <= 3; p++) begin
        if (hitOf(regAddr, p) == port_phy_tune_pkg::HIT_DRIVE) begin
          driveReg[p] <= regWrData;
        end
      end
    end
  end

  // squelch registers, only the low field is stored
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int p = 1; p <= 3; p++) begin
        squelchReg[p] <= `SQUELCH_RESET;
      end
    end else if (regWrite) begin
      for (int p = 1; p <= 3; p++) begin
        if (hitOf(regAddr, p) == port_phy_tune_pkg::HIT_SQUELCH) begin
          squelchReg[p] <= regWrData[`TUNE_FIELD_MSB:0];
        end
      end
    end
  end

  // read mux; status reads the live inputs, unmapped reads zero
  always_comb begin
    next_regRdData = `READ_IDLE;
    if (regRead) begin
      for (int p = 1; p <= 3; p++) begin
        unique case (hitOf(regAddr, p))
          port_phy_tune_pkg::HIT_DRIVE: begin
            next_regRdData = driveReg[p];
          end
          port_phy_tune_pkg::HIT_SQUELCH: begin
            next_regRdData = {5'h00, squelchReg[p]};
          end
          port_phy_tune_pkg::HIT_STATUS: begin
            next_regRdData = {linkCode[p], 1'b0, linkSub[p]};
          end
          port_phy_tune_pkg::HIT_NONE: begin
          end
        endcase
      end
    end
  end

  // read data stands for the one cycle after the strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      regRdData <= `READ_IDLE;
    end else begin
      regRdData <= next_regRdData;
    end
  end

  // decoded tuning values, one cycle behind the codes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int p = 1; p <= 3; p++) begin
        drivePct[p]  <= 6'sd0;
        tripPoint[p] <= `TRIP_NOMINAL;
      end
    end else begin
      for (int p = 1; p <= 3; p++) begin
        drivePct[p]  <= drivePctOf(driveReg[p][`TUNE_FIELD_MSB:0]);
        tripPoint[p] <= tripOf(squelchReg[p]);
      end
    end
  end

  // decoded link states, one cycle behind the inputs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int p = 1; p <= 3; p++) begin
        linkName[p]  <= port_phy_tune_pkg::LINK_UNDEFINED;
        linkValid[p] <= 1'b0;
      end
    end else begin
      for (int p = 1; p <= 3; p++) begin
        linkName[p]  <= linkNameOf(linkCode[p]);
        linkValid[p] <= (linkCode[p] <= `LINK_CODE_MAX);
      end
    end
  end

  // raw codes straight from the registers
  assign p1DriveAdjust   = driveReg[1][`TUNE_FIELD_MSB:0];
  assign p2DriveAdjust   = driveReg[2][`TUNE_FIELD_MSB:0];
  assign p3DriveAdjust   = driveReg[3][`TUNE_FIELD_MSB:0];
  assign p1SquelchAdjust = squelchReg[1];
  assign p2SquelchAdjust = squelchReg[2];
  assign p3SquelchAdjust = squelchReg[3];

  // decoded values
  assign p1DrivePercent  = drivePct[1];
  assign p2DrivePercent  = drivePct[2];
  assign p3DrivePercent  = drivePct[3];
  assign p1SquelchTrip   = tripPoint[1];
  assign p2SquelchTrip   = tripPoint[2];
  assign p3SquelchTrip   = tripPoint[3];
  assign p1LinkName      = linkName[1];
  assign p2LinkName      = linkName[2];
  assign p3LinkName      = linkName[3];
  assign p1LinkCodeValid = linkValid[1];
  assign p2LinkCodeValid = linkValid[2];
  assign p3LinkCodeValid = linkValid[3];

endmodule

// ==== test/port_phy_tune_chk.sv ====
// concurrent checks on the port tuning bank ports
module port_phy_tune_chk (
  input wire logic                            core_clk,
  input wire logic                            rst,
  input wire logic [15:0]                     regAddr,
  input wire logic [7:0]                      regWrData,
  input wire logic                            regWrite,
  input wire logic                            regRead,
  input wire logic [7:0]                      regRdData,
  input wire logic [3:0]                      p1LinkState,
  input wire logic [2:0]                      p1LinkSubState,
  input wire logic [2:0]                      p1SquelchAdjust,
  input wire logic [2:0]                      p2DriveAdjust,
  input wire logic [2:0]                      p3DriveAdjust,
  input wire port_phy_tune_pkg::drive_pct_t   p2DrivePercent,
  input wire port_phy_tune_pkg::trip_t        p1SquelchTrip,
  input wire port_phy_tune_pkg::link_state_t  p1LinkName,
  input wire logic                            p1LinkCodeValid
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0]  PCT [8] = '{6'h00, 6'h3b, 6'h0a, 6'h05, 6'h14, 6'h0f, 6'h1e, 6'h19};
  localparam logic [10:0] TRIP [8] = '{11'h3e8, 11'h36b, 11'h2ee, 11'h271,
                                       11'h1f4, 11'h177, 11'h4e2, 11'h465};
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // single-cycle access conditions
  sequence s_drvWr;
    regWrite && regAddr == 16'h68ca;
  endsequence
  sequence s_stRd;
    regRead && regAddr == 16'h65c0;
  endsequence
  property p_rdIdle;
    !$past(regRead) |-> regRdData == 8'h00;
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
  property p_stRd;
    s_stRd |=> regRdData == {$past(p1LinkState), 1'b0, $past(p1LinkSubState)};
  endproperty
  a_stRd: assert property (p_stRd) else $error("status read wrong");
  property p_sqWr;
    regWrite && regAddr == 16'h64cc |=> p1SquelchAdjust == $past(regWrData[2:0]);
  endproperty
  a_sqWr: assert property (p_sqWr) else $error("squelch write lost");
  property p_sqRes;
    regRead && regAddr == 16'h68cc |=> regRdData[7:3] == 5'h00;
  endproperty
  a_sqRes: assert property (p_sqRes) else $error("squelch reserved not zero");
  property p_drvHold;
    !(regWrite && regAddr == 16'h6cca) |=> $stable(p3DriveAdjust);
  endproperty
  a_drvHold: assert property (p_drvHold) else $error("drive code moved");
  property p_drvWr;
    s_drvWr |=> p2DriveAdjust == $past(regWrData[2:0])
      ##1 p2DrivePercent == PCT[$past(regWrData[2:0], 2)];
  endproperty
  a_drvWr: assert property (p_drvWr) else $error("drive write wrong");
  property p_pct;
    !$past(rst) |-> p2DrivePercent == PCT[$past(p2DriveAdjust)];
  endproperty
  a_pct: assert property (p_pct) else $error("drive percent wrong");
  property p_trip;
    !$past(rst) |-> p1SquelchTrip == TRIP[$past(p1SquelchAdjust)];
  endproperty
  a_trip: assert property (p_trip) else $error("trip point wrong");
  property p_name;
    !$past(rst) |-> p1LinkCodeValid == ($past(p1LinkState) <= 4'hb)
      && p1LinkName == ($past(p1LinkState) <= 4'hb ? $past(p1LinkState) : 4'hf);
  endproperty
  a_name: assert property (p_name) else $error("link name wrong");
endmodule

bind port_phy_tune_link_status_regs port_phy_tune_chk port_phy_tune_chk_inst (.*);

// ==== test/tb_port_phy_tune_link_status_regs.sv ====
// self-checking bench for the port tuning and link status bank
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_port_phy_tune_link_status_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0]  PCT [8] = '{6'h00, 6'h3b, 6'h0a, 6'h05, 6'h14, 6'h0f, 6'h1e, 6'h19};
  localparam logic [10:0] TRIP [8] = '{11'h3e8, 11'h36b, 11'h2ee, 11'h271,
                                       11'h1f4, 11'h177, 11'h4e2, 11'h465};
  localparam logic [15:0] DRV_A [3] = '{16'h64ca, 16'h68ca, 16'h6cca};
  localparam logic [15:0] SQ_A [3] = '{16'h64cc, 16'h68cc, 16'h6ccc};
  localparam logic [15:0] ST_A [3] = '{16'h65c0, 16'h69c0, 16'h6dc0};
  logic                            core_clk, rst, regWrite, regRead, rdPend;
  logic [15:0]                     regAddr;
  logic [7:0]                      regWrData, regRdData, d, s, e;
  logic [3:0]                      lnk [3];
  logic [2:0]                      sub [3], drv [3], sq [3], c, u;
  port_phy_tune_pkg::drive_pct_t   pct [3];
  port_phy_tune_pkg::trip_t        trip [3];
  port_phy_tune_pkg::link_state_t  nm [3];
  logic                            vld [3];
  logic [7:0]                      expQ [$];
  int                              errors, compares, cycles, seed = 98;

  port_phy_tune_link_status_regs port_phy_tune_link_status_regs_inst (
    .core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .p1LinkState(lnk[0]), .p1LinkSubState(sub[0]), .p2LinkState(lnk[1]),
    .p2LinkSubState(sub[1]), .p3LinkState(lnk[2]), .p3LinkSubState(sub[2]),
    .p1DriveAdjust(drv[0]), .p2DriveAdjust(drv[1]), .p3DriveAdjust(drv[2]),
    .p1SquelchAdjust(sq[0]), .p2SquelchAdjust(sq[1]), .p3SquelchAdjust(sq[2]),
    .p1DrivePercent(pct[0]), .p2DrivePercent(pct[1]), .p3DrivePercent(pct[2]),
    .p1SquelchTrip(trip[0]), .p2SquelchTrip(trip[1]), .p3SquelchTrip(trip[2]),
    .p1LinkName(nm[0]), .p2LinkName(nm[1]), .p3LinkName(nm[2]),
    .p1LinkCodeValid(vld[0]), .p2LinkCodeValid(vld[1]), .p3LinkCodeValid(vld[2]));

  // clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // one bus cycle, strobes held until the next call
  task automatic op(input logic w, input logic r, input logic [15:0] a, input logic [7:0] v);
    @(posedge core_clk);
    regWrite <= w;
    regRead <= r;
    regAddr <= a;
    regWrData <= v;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    op(1'b1, 1'b0, a, v);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] x);
    expQ.push_back(x);
    op(1'b0, 1'b1, a, $random(seed));
  endtask
  task automatic idle;
    op(1'b0, 1'b0, $random(seed), $random(seed));
    #1;
  endtask
  task automatic tune(input int p, input logic [2:0] dc, input logic [2:0] sc);
    `CHK(drv[p], dc)
    `CHK(sq[p], sc)
    `CHK(pct[p], PCT[dc])
    `CHK(trip[p], TRIP[sc])
  endtask
  task automatic end_of_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // read data monitor and timeout
  always @(posedge core_clk) begin
    if (rdPend) begin
      e = expQ.pop_front();
      `CHK(regRdData, e)
    end
    rdPend <= regRead;
    cycles++;
    if (cycles > 2000) begin
      errors++;
      end_of_test;
    end
  end

  // main sequence
  initial begin
    rst = 1'b1;
    {regWrite, regRead, rdPend, regAddr, regWrData} = '0;
    for (int p = 0; p < 3; p++) {lnk[p], sub[p]} = '0;
    repeat (10) @(posedge core_clk);
    #1;
    for (int p = 0; p < 3; p++) tune(p, 3'h0, 3'h0);
    @(posedge core_clk) rst <= 1'b0;
    // every code on every port, read back at once
    for (int p = 0; p < 3; p++)
      for (int i = 0; i < 8; i++) begin
        c = i;
        d = {$random(seed)} & 8'hf8 | c;
        s = {$random(seed)} & 8'hf8 | ~c;
        wr(DRV_A[p], d);
        wr(SQ_A[p], s);
        rd(DRV_A[p], d);
        rd(SQ_A[p], {5'h00, s[2:0]});
        idle;
        tune(p, c, ~c);
      end
    // live link status, writes ignored, every state code
    for (int n = 0; n < 16; n++)
      for (int p = 0; p < 3; p++) begin
        u = $random(seed);
        wr(ST_A[p], $random(seed));
        lnk[p] <= n;
        sub[p] <= u;
        rd(ST_A[p], {n[3:0], 1'b0, u});
        idle;
        `CHK(vld[p], (n <= 11))
        `CHK(nm[p], ((n <= 11) ? n[3:0] : 4'hf))
      end
    // second reset in mid-run, then unmapped read
    @(posedge core_clk) rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    for (int p = 0; p < 3; p++) tune(p, 3'h0, 3'h0);
    @(posedge core_clk) rst <= 1'b0;
    for (int p = 0; p < 3; p++) rd(DRV_A[p], 8'h00);
    rd(16'h6dc1, 8'h00);
    idle;
    repeat (2) @(posedge core_clk);
    end_of_test;
  end
endmodule
